// ===== tap_map.svh
// Constants of the boundary-scan test port: register sizes, codes, reset values.
// Assumes inclusion by bare name from the package and the port logic.
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH
`define IR_W 3
`define ID_W 32
`define BSR_W 109
`define PIN_CELLS 108
`define TRI_CELL 108
`define IR_EXTEST 3'h0
`define IR_IDCODE 3'h1
`define IR_SAMPLE_Z 3'h2
`define IR_SAMPLE 3'h4
`define IR_BYPASS 3'h7
`define IR_CAPTURE 3'h1
`define BYPASS_CAPTURE 1'h0
// Identification code value is arbitrary; bit 0 stays set to mark the register present.
`define ID_DEFAULT 32'h0ABC_D001
`define SYNC_STAGES 3
`define PIN_RESET 3'h3
`endif

// ===== tap_pkg.sv
// Types shared by the test-port logic and its pin sampler.
// Assumes tap_map.svh is on the include path.
`include "tap_map.svh"
package tap_pkg;
   typedef enum logic [3:0] {
      TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h3, CAP_DR = 4'h2,
      SH_DR = 4'h6, EX1_DR = 4'h7, PAU_DR = 4'h5, EX2_DR = 4'h4,
      UPD_DR = 4'hC, SEL_IR = 4'hD, CAP_IR = 4'hF, SH_IR = 4'hE,
      EX1_IR = 4'hA, PAU_IR = 4'hB, EX2_IR = 4'h9, UPD_IR = 4'h8
   } tap_state_t;
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } test_pins_t;
endpackage

// ===== pin_sampler.sv
// Three-stage sampler for the test pins with agreement filter and edge pulses.
// Assumes the pins are asynchronous to i_clk and change slower than a few clocks.
`timescale 1ns/1ns
`include "tap_map.svh"
module pin_sampler (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire tap_pkg::test_pins_t i_pins,
   output tap_pkg::test_pins_t o_level,
   output tap_pkg::test_pins_t o_rise,
   output tap_pkg::test_pins_t o_fall
);
   logic [`SYNC_STAGES-1:0] sh_q [3];
   logic [2:0] lvl_q;
   logic [2:0] rise_q;
   logic [2:0] fall_q;
   // Reset levels match the idle pins, so no false edge follows reset.
   localparam logic [2:0] pin_rst = `PIN_RESET;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_pin
         always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               sh_q[g] <= {`SYNC_STAGES{pin_rst[g]}};
            end else begin
               sh_q[g] <= {sh_q[g][`SYNC_STAGES-2:0], i_pins[g]};
            end
         end
         // Only stages two and three are compared, so the first stage feeds nothing else.
         always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               lvl_q[g] <= pin_rst[g];
               rise_q[g] <= 1'h0;
               fall_q[g] <= 1'h0;
            end else begin
               if (sh_q[g][1] == sh_q[g][2]) begin
                  lvl_q[g] <= sh_q[g][2];
               end
               rise_q[g] <= (sh_q[g][1] == sh_q[g][2]) && sh_q[g][2] && !lvl_q[g];
               fall_q[g] <= (sh_q[g][1] == sh_q[g][2]) && !sh_q[g][2] && lvl_q[g];
            end
         end
      end
   endgenerate
   assign o_level = lvl_q;
   assign o_rise = rise_q;
   assign o_fall = fall_q;
endmodule

// ===== scan_tap.sv
// Boundary-scan test access port: state machine, instruction, ID, bypass and scan cells.
// Assumes the test pins arrive asynchronously and are sampled by i_clk.
// Notes on behaviour
// - Three-bit instruction register, five codes defined.
// - Shift-IR shifts; instruction takes effect at Update-IR.
// - IDCODE captures and shifts fixed 32-bit code.
// - IDCODE becomes current at reset and Test-Logic-Reset.
// - SAMPLE Z selects scan cells, outputs high impedance.
// - Sample captures pin values at Capture-DR.
// - Scan cells shift between data in and out.
// - Update-DR copies shifted pattern to latched outputs.
// - Preload shifts in while sample shifts out.
// - BYPASS selects the single-bit bypass register.
// - EXTEST drives latched cells onto output pins.
// - Cell 108 enables read-data drivers under EXTEST.
// - Cell 108 latched from shift stage at Update-DR.
// - Cell 108 preset high at reset and Test-Logic-Reset.
// - State advances on mode select at clock rise.
// - Codes 000,001,010,100,111 decoded; others reserved.
// - Capture-IR loads 01 into low bits.
// - Inputs sampled on rise, data out changes on fall.
// - Five mode-select highs reach Test-Logic-Reset.
`timescale 1ns/1ns
`include "tap_map.svh"
module scan_tap (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic i_tdi,
   input wire logic [`PIN_CELLS-1:0] i_pin_values,
   output logic o_tdo,
   output logic o_tdo_oe_n,
   output logic [`PIN_CELLS-1:0] o_cell_values,
   output logic o_extest,
   output logic o_qbus_en
);
   tap_pkg::test_pins_t lvl;
   tap_pkg::test_pins_t rise;
   tap_pkg::test_pins_t fall;
   tap_pkg::tap_state_t state_q;
   tap_pkg::tap_state_t state_d;
   logic [`IR_W-1:0] ir_sh_q;
   logic [`IR_W-1:0] ir_q;
   logic [`ID_W-1:0] id_q;
   logic byp_q;
   logic [`BSR_W-1:0] bsr_q;
   logic [`BSR_W-1:0] upd_q;
   logic tdo_q;
   logic tdo_oe_n_q;
   logic extest_q;
   logic qbus_en_q;
   logic sel_bsr;
   logic sel_id;
   logic tlr_next;

   pin_sampler u_pins (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_pins({i_tck, i_tms, i_tdi}),
      .o_level(lvl),
      .o_rise(rise),
      .o_fall(fall)
   );

   // Scan cells serve every boundary instruction; reserved codes land on bypass.
   function automatic logic is_bsr(input logic [`IR_W-1:0] code);
      return code == `IR_EXTEST || code == `IR_SAMPLE_Z || code == `IR_SAMPLE;
   endfunction

   function automatic logic is_id(input logic [`IR_W-1:0] code);
      return code == `IR_IDCODE;
   endfunction

   function automatic logic is_shift(input tap_pkg::tap_state_t st);
      return st == tap_pkg::SH_DR || st == tap_pkg::SH_IR;
   endfunction

   assign sel_bsr = is_bsr(ir_q);
   assign sel_id = is_id(ir_q);
   // Acting on the move into reset, not on the next rise in it, leaves no tck period
   // with a stale instruction or a low control cell after five mode-select highs.
   assign tlr_next = state_d == tap_pkg::TLR;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         tap_pkg::TLR: state_d = lvl.tms ? tap_pkg::TLR : tap_pkg::RTI;
         tap_pkg::RTI: state_d = lvl.tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
         tap_pkg::SEL_DR: state_d = lvl.tms ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
         tap_pkg::CAP_DR: state_d = lvl.tms ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
         tap_pkg::SH_DR: state_d = lvl.tms ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
         tap_pkg::EX1_DR: state_d = lvl.tms ? tap_pkg::UPD_DR : tap_pkg::PAU_DR;
         tap_pkg::PAU_DR: state_d = lvl.tms ? tap_pkg::EX2_DR : tap_pkg::PAU_DR;
         tap_pkg::EX2_DR: state_d = lvl.tms ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
         tap_pkg::UPD_DR: state_d = lvl.tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
         tap_pkg::SEL_IR: state_d = lvl.tms ? tap_pkg::TLR : tap_pkg::CAP_IR;
         tap_pkg::CAP_IR: state_d = lvl.tms ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
         tap_pkg::SH_IR: state_d = lvl.tms ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
         tap_pkg::EX1_IR: state_d = lvl.tms ? tap_pkg::UPD_IR : tap_pkg::PAU_IR;
         tap_pkg::PAU_IR: state_d = lvl.tms ? tap_pkg::EX2_IR : tap_pkg::PAU_IR;
         tap_pkg::EX2_IR: state_d = lvl.tms ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
         tap_pkg::UPD_IR: state_d = lvl.tms ? tap_pkg::SEL_DR : tap_pkg::RTI;
      endcase
   end

   // The filtered mode-select level is settled well before the detected clock rise.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= tap_pkg::TLR;
      end else if (rise.tck) begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ir_sh_q <= `IR_IDCODE;
         ir_q <= `IR_IDCODE;
      end else if (rise.tck && tlr_next) begin
         ir_q <= `IR_IDCODE;
      end else if (rise.tck) begin
         unique case (state_q)
            tap_pkg::TLR: ir_q <= `IR_IDCODE;
            tap_pkg::CAP_IR: ir_sh_q <= `IR_CAPTURE;
            tap_pkg::SH_IR: ir_sh_q <= {lvl.tdi, ir_sh_q[`IR_W-1:1]};
            tap_pkg::UPD_IR: ir_q <= ir_sh_q;
            default: ir_q <= ir_q;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         id_q <= `ID_DEFAULT;
      end else if (rise.tck) begin
         if (state_q == tap_pkg::CAP_DR) begin
            id_q <= `ID_DEFAULT;
         end else if (state_q == tap_pkg::SH_DR && sel_id) begin
            id_q <= {lvl.tdi, id_q[`ID_W-1:1]};
         end
      end
   end

   // Reserved codes fall through to bypass, so a stray load only lengthens the chain by one.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         byp_q <= `BYPASS_CAPTURE;
      end else if (rise.tck) begin
         if (state_q == tap_pkg::CAP_DR) begin
            byp_q <= `BYPASS_CAPTURE;
         end else if (state_q == tap_pkg::SH_DR && !sel_id && !sel_bsr) begin
            byp_q <= lvl.tdi;
         end
      end
   end

   // The internal control cell captures its latched value since it has no pin.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         bsr_q <= {`BSR_W{1'h0}};
      end else if (rise.tck && sel_bsr) begin
         if (state_q == tap_pkg::CAP_DR) begin
            bsr_q <= {upd_q[`TRI_CELL], i_pin_values};
         end else if (state_q == tap_pkg::SH_DR) begin
            bsr_q <= {lvl.tdi, bsr_q[`BSR_W-1:1]};
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         upd_q <= {1'h1, {`PIN_CELLS{1'h0}}};
      end else if (rise.tck) begin
         if (state_q == tap_pkg::TLR || tlr_next) begin
            upd_q[`TRI_CELL] <= 1'h1;
         end else if (state_q == tap_pkg::UPD_DR && sel_bsr) begin
            upd_q <= bsr_q;
         end
      end
   end

   // Data out moves on the detected falling edge, half a test clock after the shift.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tdo_q <= 1'h0;
         tdo_oe_n_q <= 1'h1;
      end else if (fall.tck) begin
         tdo_oe_n_q <= !is_shift(state_q);
         if (state_q == tap_pkg::SH_IR) begin
            tdo_q <= ir_sh_q[0];
         end else if (sel_id) begin
            tdo_q <= id_q[0];
         end else if (sel_bsr) begin
            tdo_q <= bsr_q[0];
         end else begin
            tdo_q <= byp_q;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         extest_q <= 1'h0;
         qbus_en_q <= 1'h1;
      end else begin
         extest_q <= ir_q == `IR_EXTEST;
         if (ir_q == `IR_SAMPLE_Z) begin
            qbus_en_q <= 1'h0;
         end else if (ir_q == `IR_EXTEST) begin
            qbus_en_q <= upd_q[`TRI_CELL];
         end else begin
            qbus_en_q <= 1'h1;
         end
      end
   end

   assign o_tdo = tdo_q;
   assign o_tdo_oe_n = tdo_oe_n_q;
   assign o_cell_values = upd_q[`PIN_CELLS-1:0];
   assign o_extest = extest_q;
   assign o_qbus_en = qbus_en_q;
endmodule

// ===== tap_props_properties.sv
// Concurrent checks on the ports of the scan test port.
// Assumes a tck much slower than i_clk, as the pin sampler requires.
`timescale 1ns/1ns
`include "tap_map.svh"
module tap_props (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic o_tdo,
   input wire logic o_tdo_oe_n,
   input wire logic [`PIN_CELLS-1:0] o_cell_values,
   input wire logic o_extest,
   input wire logic o_qbus_en
);
   logic tck_q;
   logic [2:0] hi_q;
   // Raw rises with mode select high, saturating at five; the sampler lag is covered by a window.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tck_q <= 1'h0;
         hi_q <= 3'h0;
      end else begin
         tck_q <= i_tck;
         if (i_tck && !tck_q) begin
            hi_q <= !i_tms ? 3'h0 : (hi_q == 3'h5) ? hi_q : hi_q + 3'h1;
         end
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   tdo_fall_a: assert property ($changed(o_tdo) |-> !$past(i_tck, 3))
      else $error("tdo moved outside tck low");
   oe_fall_a: assert property ($changed(o_tdo_oe_n) |-> !$past(i_tck, 3))
      else $error("tdo enable moved outside tck low");
   oe_hold_a: assert property ($fell(o_tdo_oe_n) |-> !o_tdo_oe_n [*8])
      else $error("tdo enable shorter than a shift bit");
   rst_val_a: assert property ($rose(i_rstn) |-> o_tdo_oe_n && o_qbus_en && !o_extest)
      else $error("outputs wrong after reset");
   cell_upd_a: assert property ($changed(o_cell_values) |-> $past(i_tck, 3))
      else $error("cells latched outside tck rise");
   ext_upd_a: assert property ($changed(o_extest) |-> $past(i_tck, 4))
      else $error("extest moved outside tck rise");
   bus_upd_a: assert property ($changed(o_qbus_en) |-> $past(i_tck, 4))
      else $error("bus enable moved outside tck rise");
   tlr_clr_a: assert property ((hi_q == 3'h5) |-> ##[0:12] (o_qbus_en && !o_extest))
      else $error("five mode highs did not reset");
endmodule
bind scan_tap tap_props u_props (.i_clk(i_clk), .i_rstn(i_rstn), .i_tck(i_tck),
   .i_tms(i_tms), .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n), .o_cell_values(o_cell_values),
   .o_extest(o_extest), .o_qbus_en(o_qbus_en));

// ===== scan_ctl.sv
// Model of the external boundary-scan controller: makes tck, tms and tdi, reads tdo.
// Assumes i_clk at 50 MHz; one tck bit spans about eight clocks, 160 ns.
`timescale 1ns/1ns
module scan_ctl (
   input wire logic i_clk,
   input wire logic i_tdo,
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi
);
   // Tck stands low between frames; tdi rests at its pull-up level.
   initial begin
      o_tck = 1'h0;
      o_tms = 1'h1;
      o_tdi = 1'h1;
   end
   // The sampler puts tdo some clocks after the fall, past the next rise at this tck rate,
   // so the bit is read at the end of the high phase, where it still shows the last fall.
   task automatic step(input logic m, input logic d, output logic q);
      o_tms = m;
      o_tdi = d;
      repeat (4) @(posedge i_clk);
      #1 o_tck = 1'h1;
      repeat (4) @(posedge i_clk);
      #1 q = i_tdo;
      o_tck = 1'h0;
   endtask
   task automatic scan(input logic ir, input int n, input logic [108:0] din,
      output logic [108:0] dout);
      logic b;
      dout = '0;
      @(posedge i_clk) #1;
      // Parks in idle first, so a frame may also start from test-logic-reset.
      step(1'h0, 1'h1, b);
      step(1'h1, 1'h1, b);
      if (ir) step(1'h1, 1'h1, b);
      step(1'h0, 1'h1, b);
      step(1'h0, 1'h1, b);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], b);
         dout[i] = b;
      end
      step(1'h1, 1'h1, b);
      step(1'h0, 1'h1, b);
      o_tdi = 1'h1;
      repeat (8) @(posedge i_clk);
      #1;
   endtask
   task automatic tlr();
      logic b;
      @(posedge i_clk) #1;
      repeat (5) step(1'h1, 1'h1, b);
      step(1'h0, 1'h1, b);
      repeat (8) @(posedge i_clk);
      #1;
   endtask
endmodule

// ===== tb_top.sv
// Self-checking bench for the scan test port, driven through the controller model.
// Assumes tap_map.svh on the include path.
`timescale 1ns/1ns
`include "tap_map.svh"
module tb_top;
   logic i_clk = 1'h0;
   logic i_rstn = 1'h0;
   logic [`PIN_CELLS-1:0] pins = '0;
   logic [`PIN_CELLS-1:0] cells;
   logic [`BSR_W-1:0] pat, got;
   logic tck, tms, tdi, tdo, oe_n, extest, qbus_en;
   int failures = 0;
   int n_tests = 0;
   always #10 i_clk = ~i_clk;
   // A released tdo shows the inverse so a stale value never passes.
   scan_ctl ctl (.i_clk(i_clk), .i_tdo(oe_n ? ~tdo : tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
   scan_tap dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
      .i_pin_values(pins), .o_tdo(tdo), .o_tdo_oe_n(oe_n), .o_cell_values(cells),
      .o_extest(extest), .o_qbus_en(qbus_en));
   task automatic chk(input string nm, input logic [108:0] e, input logic [108:0] s);
      n_tests++;
      if (e !== s) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic ir(input logic [2:0] code);
      ctl.scan(1'h1, `IR_W, {106'h0, code}, got);
      chk("ir capture", 2'h1, got[1:0]);
   endtask
   task automatic t_id();
      ctl.scan(1'h0, `ID_W, '0, got);
      chk("idcode", `ID_DEFAULT, got[`ID_W-1:0]);
      chk("tdo idle", 1'h1, oe_n);
      $display("test idcode done");
   endtask
   task automatic t_bypass();
      ir(`IR_BYPASS);
      ctl.scan(1'h0, 2, 109'h1, got);
      chk("bypass", 2'h2, got[1:0]);
      $display("test bypass done");
   endtask
   task automatic t_sample();
      pins = {{26{4'h5}}, 4'hC};
      pat = {1'h0, {27{4'h3}}};
      ir(`IR_SAMPLE);
      ctl.scan(1'h0, `BSR_W, pat, got);
      chk("sample", {1'h1, pins}, got);
      chk("preload", pat[107:0], cells);
      chk("bus on", 1'h1, qbus_en);
      ir(`IR_SAMPLE_Z);
      chk("bus off", 1'h0, qbus_en);
      ctl.scan(1'h0, `BSR_W, pat, got);
      chk("z shift", {1'h0, pins}, got);
      ir(`IR_IDCODE);
      chk("bus back", 1'h1, qbus_en);
      $display("test sample done");
   endtask
   task automatic t_extest();
      ir(`IR_EXTEST);
      chk("extest off", 2'h2, {extest, qbus_en});
      ctl.scan(1'h0, `BSR_W, ~pat, got);
      chk("extest shift", {1'h0, pins}, got);
      chk("drive", ~pat, {qbus_en, cells});
      ctl.scan(1'h0, `BSR_W, pat, got);
      chk("tri cell", 1'h0, qbus_en);
      ctl.tlr();
      chk("reset", 2'h1, {extest, qbus_en});
      $display("test extest done");
   endtask
   task automatic conclude();
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge i_clk);
      #1 i_rstn = 1'h1;
      repeat (4) @(posedge i_clk);
      t_id();
      t_bypass();
      t_sample();
      t_extest();
      t_id();
      conclude();
   end
   initial begin
      #1000000;
      failures++;
      conclude();
   end
endmodule
